// ### rtl/pcs_pkg.sv
// Constants and types shared by the card status input block
`default_nettype none
package pcs_pkg;
	// Geometry of the block
	localparam int SOCKETS = 2;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int SYNC_STAGES = 2;
	// Register offsets on the plain register port
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_CONFIG = 4'h1;
	localparam logic [3:0] REG_EVENT = 4'h2;
	localparam logic [3:0] REG_MASK = 4'h3;
	// Width of one socket's slice in each register
	localparam int STAT_W = 8;
	localparam int CFG_W = 4;
	localparam int EVT_W = 4;
	// Status slice field positions
	localparam int ST_PRESENT = 0;
	localparam int ST_BATT = 1;
	localparam int ST_ALERT = 3;
	localparam int ST_RING = 4;
	localparam int ST_DMA = 5;
	localparam int ST_AUDIO = 6;
	localparam int ST_IOMODE = 7;
	// Configuration slice field positions
	localparam int CF_IOMODE = 0;
	localparam int CF_RING = 1;
	localparam int CF_DMA = 2;
	// Event and mask slice field positions
	localparam int EV_INSERT = 0;
	localparam int EV_BATT = 1;
	localparam int EV_ALERT = 2;
	localparam int EV_RING = 3;
	// Reset values of the writable registers
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	// Pin levels at which the card asserts its alert and DMA request
	localparam logic ALERT_ACTIVE = 1'b0;
	localparam logic DMAREQ_ACTIVE = 1'b0;
	// Pin order inside one socket's synchroniser bundle
	localparam int PIN_FIRST = 0;
	localparam int PIN_SECOND = 1;
	localparam int PIN_SENSE_ONE = 2;
	localparam int PIN_SENSE_TWO = 3;
	localparam int PINS = 4;
	// Battery condition of a memory card
	typedef enum logic [1:0] {
		PCS_BATT_GOOD = 2'b00,
		PCS_BATT_WEAK = 2'b01,
		PCS_BATT_DEAD = 2'b10
	} pcs_batt_t;
endpackage
`default_nettype wire

// ### rtl/pcs_sync.sv
// Two-stage synchroniser for a bundle of asynchronous card pins
`default_nettype none
module pcs_sync #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stageOne;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stageOne <= '1;
			syncOut <= '1;
		end else begin
			stageOne <= asyncIn;
			syncOut <= stageOne;
		end
	end

	chk_sync_two_stage: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst, 2) && !$past(rst) |-> syncOut == $past(asyncIn, 2))
		else $error("synchroniser output is not the input two cycles back");
endmodule
`default_nettype wire

// ### rtl/pcs_socket.sv
// Decoder for one socket's card status pins
`default_nettype none
module pcs_socket (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic firstPin,
	input wire logic secondPin,
	input wire logic senseOneN,
	input wire logic senseTwoN,
	input wire logic ioMode,
	input wire logic ringMode,
	input wire logic dmaMode,
	output var pcs_pkg::pcs_batt_t batteryState,
	output logic present,
	output logic cardChangeAlert,
	output logic phoneCallAlert,
	output logic dmaRequest,
	output logic cardAudioIn
);
	logic firstActive;
	logic secondActive;

	// Battery condition from the two sense lines of a memory card
	function automatic pcs_pkg::pcs_batt_t decodeBattery(input logic first, input logic second);
		if (!first) begin
			return pcs_pkg::PCS_BATT_DEAD;
		end else if (!second) begin
			return pcs_pkg::PCS_BATT_WEAK;
		end
		return pcs_pkg::PCS_BATT_GOOD;
	endfunction

	// Asserted levels of the two multi-role pins
	assign firstActive = (firstPin == pcs_pkg::ALERT_ACTIVE);
	assign secondActive = (secondPin == pcs_pkg::DMAREQ_ACTIVE);

	// Presence and battery state; battery lines mean nothing in I/O mode
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			present <= 1'b0;
			batteryState <= pcs_pkg::PCS_BATT_GOOD;
		end else begin
			present <= !senseOneN && !senseTwoN;
			batteryState <= ioMode ? pcs_pkg::PCS_BATT_GOOD : decodeBattery(firstPin, secondPin);
		end
	end

	// I/O roles of the first pin, second pin as DMA request or audio
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cardChangeAlert <= 1'b0;
			phoneCallAlert <= 1'b0;
			dmaRequest <= 1'b0;
			cardAudioIn <= 1'b0;
		end else begin
			cardChangeAlert <= ioMode && !ringMode && firstActive;
			phoneCallAlert <= ioMode && ringMode && firstActive;
			dmaRequest <= dmaMode && secondActive;
			cardAudioIn <= ioMode && !dmaMode && secondPin;
		end
	end

	chk_batt_good: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) && $past(!ioMode && firstPin && secondPin)
		|-> batteryState == pcs_pkg::PCS_BATT_GOOD)
		else $error("good battery not reported");
	chk_batt_weak: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) && $past(!ioMode && firstPin && !secondPin)
		|-> batteryState == pcs_pkg::PCS_BATT_WEAK)
		else $error("weak battery not reported");
	chk_batt_dead: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) && $past(!ioMode && !firstPin)
		|-> batteryState == pcs_pkg::PCS_BATT_DEAD)
		else $error("dead battery not reported");
	chk_alert_role: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) |-> cardChangeAlert == $past(ioMode && !ringMode && firstActive))
		else $error("status change alert does not follow the first pin");
	chk_ring_role: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) && $past(ioMode && ringMode && firstActive)
		|-> phoneCallAlert ##1 (!phoneCallAlert || $past(firstActive)))
		else $error("ring indication does not follow the first pin");
	chk_audio_gate: assert property (
		@(posedge sys_clk) disable iff (rst)
		$past(!ioMode) |-> !cardAudioIn)
		else $error("audio passed outside I/O mode");
	chk_dma_request: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) |-> dmaRequest == $past(dmaMode && secondActive))
		else $error("DMA request does not follow the second pin");
	chk_presence: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) |-> present == $past(!senseOneN && !senseTwoN))
		else $error("presence does not follow both insert sense lines");
endmodule
`default_nettype wire

// ### rtl/pcs_status_inputs.sv
// Card status inputs of a dual-socket card controller, with register port
`default_nettype none
// Function
// - Both battery lines high means the memory card battery is good.
// - Second battery line low, first high, means a weak battery.
// - First battery line low means a dead battery and lost contents.
// - In I/O mode the first line is a status change alert passed on.
// - For modem cards the first line may be a ring event instead.
// - Second line is binary audio only in I/O mode.
// - Audio from both sockets merges into one speaker output.
// - The speaker output is the XOR of the socket audio inputs.
// - During DMA the card asserts the second line as the DMA request.
// - Both insert sense lines low means a card is present.
module pcs_status_inputs #(
	parameter int SOCKETS = pcs_pkg::SOCKETS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [SOCKETS-1:0] batterySenseFirst,
	input wire logic [SOCKETS-1:0] batterySenseSecond,
	input wire logic [SOCKETS-1:0] insertSenseOneN,
	input wire logic [SOCKETS-1:0] insertSenseTwoN,
	input wire logic [pcs_pkg::ADDR_W-1:0] regAddr,
	input wire logic [pcs_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [pcs_pkg::DATA_W-1:0] regRdData,
	output logic irq,
	output logic mergedAudioOut,
	output logic [SOCKETS-1:0] cardChangeAlert,
	output logic [SOCKETS-1:0] phoneCallAlert,
	output logic [SOCKETS-1:0] dmaRequest,
	output logic [SOCKETS-1:0] cardPresent
);
	localparam int PIN_BITS = SOCKETS * pcs_pkg::PINS;
	localparam int STAT_BITS = SOCKETS * pcs_pkg::STAT_W;
	localparam int CFG_BITS = SOCKETS * pcs_pkg::CFG_W;
	localparam int EVT_BITS = SOCKETS * pcs_pkg::EVT_W;

	logic [PIN_BITS-1:0] pinsRaw;
	logic [PIN_BITS-1:0] pinsSync;
	logic [CFG_BITS-1:0] configReg;
	logic [EVT_BITS-1:0] eventReg;
	logic [EVT_BITS-1:0] maskReg;
	logic [EVT_BITS-1:0] eventSet;
	logic [EVT_BITS-1:0] eventClear;
	logic [STAT_BITS-1:0] statusWord;
	logic [SOCKETS-1:0] present;
	logic [SOCKETS-1:0] alert;
	logic [SOCKETS-1:0] ring;
	logic [SOCKETS-1:0] dmaReq;
	logic [SOCKETS-1:0] audio;
	logic [SOCKETS-1:0] prevPresent;
	logic [SOCKETS-1:0] prevAlert;
	logic [SOCKETS-1:0] prevRing;
	pcs_pkg::pcs_batt_t battery [SOCKETS];
	pcs_pkg::pcs_batt_t prevBattery [SOCKETS];
	logic writeConfig;
	logic writeEvent;
	logic writeMask;

	// True when a strobe targets the given register offset
	function automatic logic hits(input logic strobe, input logic [pcs_pkg::ADDR_W-1:0] addr,
		input logic [3:0] offset);
		return strobe && (addr == offset);
	endfunction

	// Gather the raw pins of every socket into one synchroniser bundle
	always_comb begin
		pinsRaw = '0;
		for (int s = 0; s < SOCKETS; s++) begin
			pinsRaw[s * pcs_pkg::PINS + pcs_pkg::PIN_FIRST] = batterySenseFirst[s];
			pinsRaw[s * pcs_pkg::PINS + pcs_pkg::PIN_SECOND] = batterySenseSecond[s];
			pinsRaw[s * pcs_pkg::PINS + pcs_pkg::PIN_SENSE_ONE] = insertSenseOneN[s];
			pinsRaw[s * pcs_pkg::PINS + pcs_pkg::PIN_SENSE_TWO] = insertSenseTwoN[s];
		end
	end

	// Card pins change at any time, so they cross in two stages first
	pcs_sync #(
		.WIDTH(PIN_BITS)
	) pinSync (
		.sys_clk(sys_clk),
		.rst(rst),
		.asyncIn(pinsRaw),
		.syncOut(pinsSync)
	);

	// One decoder per socket, steered by that socket's configuration slice
	for (genvar s = 0; s < SOCKETS; s++) begin : gSocket
		pcs_socket decoder (
			.sys_clk(sys_clk),
			.rst(rst),
			.firstPin(pinsSync[s * pcs_pkg::PINS + pcs_pkg::PIN_FIRST]),
			.secondPin(pinsSync[s * pcs_pkg::PINS + pcs_pkg::PIN_SECOND]),
			.senseOneN(pinsSync[s * pcs_pkg::PINS + pcs_pkg::PIN_SENSE_ONE]),
			.senseTwoN(pinsSync[s * pcs_pkg::PINS + pcs_pkg::PIN_SENSE_TWO]),
			.ioMode(configReg[s * pcs_pkg::CFG_W + pcs_pkg::CF_IOMODE]),
			.ringMode(configReg[s * pcs_pkg::CFG_W + pcs_pkg::CF_RING]),
			.dmaMode(configReg[s * pcs_pkg::CFG_W + pcs_pkg::CF_DMA]),
			.batteryState(battery[s]),
			.present(present[s]),
			.cardChangeAlert(alert[s]),
			.phoneCallAlert(ring[s]),
			.dmaRequest(dmaReq[s]),
			.cardAudioIn(audio[s])
		);
	end

	// Write strobe decode
	assign writeConfig = hits(regWrite, regAddr, pcs_pkg::REG_CONFIG);
	assign writeEvent = hits(regWrite, regAddr, pcs_pkg::REG_EVENT);
	assign writeMask = hits(regWrite, regAddr, pcs_pkg::REG_MASK);

	// Configuration register selects I/O, ring and DMA roles per socket
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			configReg <= pcs_pkg::CONFIG_RESET[CFG_BITS-1:0];
		end else if (writeConfig) begin
			configReg <= regWrData[CFG_BITS-1:0];
		end
	end

	// Interrupt mask, same layout as the event register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			maskReg <= pcs_pkg::MASK_RESET[EVT_BITS-1:0];
		end else if (writeMask) begin
			maskReg <= regWrData[EVT_BITS-1:0];
		end
	end

	// Previous decoded state, used to find changes and rising alerts
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prevPresent <= '0;
			prevAlert <= '0;
			prevRing <= '0;
			for (int s = 0; s < SOCKETS; s++) begin
				prevBattery[s] <= pcs_pkg::PCS_BATT_GOOD;
			end
		end else begin
			prevPresent <= present;
			prevAlert <= alert;
			prevRing <= ring;
			for (int s = 0; s < SOCKETS; s++) begin
				prevBattery[s] <= battery[s];
			end
		end
	end

	// Events: insertion change, battery change, rising alert, rising ring
	always_comb begin
		eventSet = '0;
		for (int s = 0; s < SOCKETS; s++) begin
			eventSet[s * pcs_pkg::EVT_W + pcs_pkg::EV_INSERT] = present[s] != prevPresent[s];
			eventSet[s * pcs_pkg::EVT_W + pcs_pkg::EV_BATT] =
				present[s] && (battery[s] != prevBattery[s]);
			eventSet[s * pcs_pkg::EVT_W + pcs_pkg::EV_ALERT] =
				present[s] && alert[s] && !prevAlert[s];
			eventSet[s * pcs_pkg::EVT_W + pcs_pkg::EV_RING] =
				present[s] && ring[s] && !prevRing[s];
		end
	end

	// Writing a one clears an event bit
	assign eventClear = writeEvent ? regWrData[EVT_BITS-1:0] : '0;

	// Sticky events; a new event beats a clear in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			eventReg <= '0;
		end else begin
			eventReg <= (eventReg & ~eventClear) | eventSet;
		end
	end

	// Level interrupt while any unmasked event is pending
	assign irq = |(eventReg & maskReg);

	// Live status word assembled from the socket decoders
	always_comb begin
		statusWord = '0;
		for (int s = 0; s < SOCKETS; s++) begin
			statusWord[s * pcs_pkg::STAT_W + pcs_pkg::ST_PRESENT] = present[s];
			statusWord[s * pcs_pkg::STAT_W + pcs_pkg::ST_BATT +: 2] = battery[s];
			statusWord[s * pcs_pkg::STAT_W + pcs_pkg::ST_ALERT] = alert[s];
			statusWord[s * pcs_pkg::STAT_W + pcs_pkg::ST_RING] = ring[s];
			statusWord[s * pcs_pkg::STAT_W + pcs_pkg::ST_DMA] = dmaReq[s];
			statusWord[s * pcs_pkg::STAT_W + pcs_pkg::ST_AUDIO] = audio[s];
			statusWord[s * pcs_pkg::STAT_W + pcs_pkg::ST_IOMODE] =
				configReg[s * pcs_pkg::CFG_W + pcs_pkg::CF_IOMODE];
		end
	end

	// Read data stands for the one cycle after the read strobe, else zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			regRdData <= '0;
		end else if (regRead) begin
			case (regAddr)
				pcs_pkg::REG_STATUS: begin
					regRdData <= pcs_pkg::DATA_W'(statusWord);
				end
				pcs_pkg::REG_CONFIG: begin
					regRdData <= pcs_pkg::DATA_W'(configReg);
				end
				pcs_pkg::REG_EVENT: begin
					regRdData <= pcs_pkg::DATA_W'(eventReg);
				end
				pcs_pkg::REG_MASK: begin
					regRdData <= pcs_pkg::DATA_W'(maskReg);
				end
				default: begin
					regRdData <= '0;
				end
			endcase
		end else begin
			regRdData <= '0;
		end
	end

	// Speaker output: XOR of every socket's gated audio
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mergedAudioOut <= 1'b0;
		end else begin
			mergedAudioOut <= ^audio;
		end
	end

	// Per-socket levels toward the host, already registered in the decoders
	assign cardChangeAlert = alert;
	assign phoneCallAlert = ring;
	assign dmaRequest = dmaReq;
	assign cardPresent = present;

	chk_audio_merge: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) |-> mergedAudioOut == $past(^audio))
		else $error("speaker output is not the XOR of the socket audio");
	chk_audio_single: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) && $past(audio == SOCKETS'(1)) |-> mergedAudioOut)
		else $error("audio from one socket does not reach the speaker");
	chk_event_sticky: assert property (
		@(posedge sys_clk) disable iff (rst)
		$past(eventReg[0]) && !$past(eventClear[0]) |-> eventReg[0])
		else $error("event bit dropped without a clear");
	chk_event_setwins: assert property (
		@(posedge sys_clk) disable iff (rst)
		$past(eventSet[0] && eventClear[0]) |-> eventReg[0])
		else $error("event lost to a clear in the same cycle");
	chk_ring_event: assert property (
		@(posedge sys_clk) disable iff (rst)
		present[0] && ring[0] && !prevRing[0] ##1 1'b1 |-> eventReg[pcs_pkg::EV_RING])
		else $error("ring edge did not set its event bit");
	chk_irq_level: assert property (
		@(posedge sys_clk) disable iff (rst)
		$past(|(eventSet & maskReg)) && !$past(writeMask) |-> irq)
		else $error("unmasked event did not raise the interrupt");
	chk_read_slot: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(regRead) |-> regRdData == '0)
		else $error("read data outside the slot after a read strobe");
	chk_read_config: assert property (
		@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == pcs_pkg::REG_CONFIG && !regWrite
		|=> regRdData == pcs_pkg::DATA_W'($past(configReg)))
		else $error("configuration read returns the wrong value");

	// Register port: writes land, the status offset ignores writes, reads return their word
	chk_config_write: assert property (
		@(posedge sys_clk) disable iff (rst)
		$past(writeConfig) |-> configReg == $past(regWrData[CFG_BITS-1:0]))
		else $error("configuration write did not land");
	chk_mask_write: assert property (
		@(posedge sys_clk) disable iff (rst)
		$past(writeMask) |-> maskReg == $past(regWrData[EVT_BITS-1:0]))
		else $error("mask write did not land");
	chk_status_readonly: assert property (
		@(posedge sys_clk) disable iff (rst)
		$past(regWrite && regAddr == pcs_pkg::REG_STATUS)
		|-> $stable(configReg) && $stable(maskReg))
		else $error("write to the status offset changed a register");
	chk_read_status: assert property (
		@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == pcs_pkg::REG_STATUS
		|=> regRdData == pcs_pkg::DATA_W'($past(statusWord)))
		else $error("status read returns the wrong value");
	chk_read_event: assert property (
		@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == pcs_pkg::REG_EVENT
		|=> regRdData == pcs_pkg::DATA_W'($past(eventReg)))
		else $error("event read returns the wrong value");
	chk_read_mask: assert property (
		@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == pcs_pkg::REG_MASK
		|=> regRdData == pcs_pkg::DATA_W'($past(maskReg)))
		else $error("mask read returns the wrong value");
	chk_read_unmapped: assert property (
		@(posedge sys_clk) disable iff (rst)
		regRead && regAddr > pcs_pkg::REG_MASK |=> regRdData == '0)
		else $error("unmapped offset did not read as zero");

	// Sticky event bits of socket 0 follow their sources and the write-one clear
	chk_insert_event: assert property (
		@(posedge sys_clk) disable iff (rst)
		$past(present[0] != prevPresent[0]) |-> eventReg[pcs_pkg::EV_INSERT])
		else $error("insertion change did not set its event bit");
	chk_batt_event: assert property (
		@(posedge sys_clk) disable iff (rst)
		$past(present[0] && battery[0] != prevBattery[0]) |-> eventReg[pcs_pkg::EV_BATT])
		else $error("battery change did not set its event bit");
	chk_alert_event: assert property (
		@(posedge sys_clk) disable iff (rst)
		$past(present[0] && alert[0] && !prevAlert[0]) |-> eventReg[pcs_pkg::EV_ALERT])
		else $error("alert edge did not set its event bit");
	chk_event_clear: assert property (
		@(posedge sys_clk) disable iff (rst)
		$past(writeEvent && regWrData[0] && !eventSet[0]) |-> !eventReg[0])
		else $error("event bit survived a write-one clear");

	// Decoded roles of socket 0 against its synchronised pins and configuration, then quiet speaker and interrupt
	chk_audio_pass: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) && $past(configReg[pcs_pkg::CF_IOMODE] && !configReg[pcs_pkg::CF_DMA])
		|-> audio[0] == $past(pinsSync[pcs_pkg::PIN_SECOND]))
		else $error("audio does not follow the second pin in I/O mode");
	chk_role_excl: assert property (
		@(posedge sys_clk) disable iff (rst)
		!(alert[0] && ring[0]))
		else $error("status change alert and ring raised together");
	chk_present_both: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) && present[0]
		|-> $past(!pinsSync[pcs_pkg::PIN_SENSE_ONE] && !pinsSync[pcs_pkg::PIN_SENSE_TWO]))
		else $error("presence shown without both insert sense lines low");
	chk_merge_quiet: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) && $past(audio == '0) |-> !mergedAudioOut)
		else $error("speaker output active with no socket audio");
	chk_irq_quiet: assert property (
		@(posedge sys_clk) disable iff (rst)
		$past(eventReg == '0 && eventSet == '0) |-> !irq)
		else $error("interrupt raised with no pending event");
endmodule
`default_nettype wire

// ### bench/pcs_card_model.sv
// Behavioural model of the two cards seated in the sockets
`default_nettype none
module pcs_card_model (
	input wire logic [1:0] inserted,
	input wire logic [1:0] firstLvl,
	input wire logic [1:0] secondLvl,
	output logic [1:0] batterySenseFirst,
	output logic [1:0] batterySenseSecond,
	output logic [1:0] insertSenseOneN,
	output logic [1:0] insertSenseTwoN
);
	timeunit 1ns;
	timeprecision 1ps;
	// A seated card grounds both sense lines; an empty socket leaves them on the pull-up
	assign insertSenseOneN = ~inserted;
	assign insertSenseTwoN = ~inserted;
	// Battery, alert and ring levels of a seated card; pulled high when the socket is empty
	assign batterySenseFirst = firstLvl | ~inserted;
	// Battery, DMA request and audio levels of a seated card; pulled high when empty
	assign batterySenseSecond = secondLvl | ~inserted;
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the card status input block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] inserted = 2'b00;
	logic [1:0] firstLvl = 2'b11;
	logic [1:0] secondLvl = 2'b11;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	wire logic [1:0] bsFirst, bsSecond, senseOneN, senseTwoN;
	logic [15:0] regRdData;
	logic irq, mergedAudioOut;
	logic [1:0] cardChangeAlert, phoneCallAlert, dmaRequest, cardPresent;
	int errors = 0;
	int cmp_count = 0;
	int seed = 32'h0df2b92f;
	logic [15:0] rd;
	logic [7:0] cfg;
	logic [1:0] f, s;
	logic [7:0] cfgTab [4] = '{8'h00, 8'h11, 8'h33, 8'h45};

	// Free-running system clock
	always #5 sys_clk = ~sys_clk;

	pcs_card_model u_pcs_card_model (.inserted(inserted), .firstLvl(firstLvl),
		.secondLvl(secondLvl), .batterySenseFirst(bsFirst), .batterySenseSecond(bsSecond),
		.insertSenseOneN(senseOneN), .insertSenseTwoN(senseTwoN));

	pcs_status_inputs #(.SOCKETS(2)) u_pcs_status_inputs (.sys_clk(sys_clk), .rst(rst),
		.batterySenseFirst(bsFirst), .batterySenseSecond(bsSecond),
		.insertSenseOneN(senseOneN), .insertSenseTwoN(senseTwoN), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .irq(irq), .mergedAudioOut(mergedAudioOut),
		.cardChangeAlert(cardChangeAlert), .phoneCallAlert(phoneCallAlert),
		.dmaRequest(dmaRequest), .cardPresent(cardPresent));

	// Expected status slice of one socket from its pin levels and configuration
	function automatic logic [7:0] expSlice(input logic pres, input logic fl, input logic sl,
		input logic [3:0] c);
		logic [7:0] v;
		logic io;
		io = c[pcs_pkg::CF_IOMODE];
		v = 8'h00;
		v[pcs_pkg::ST_PRESENT] = pres;
		if (!io)
			v[pcs_pkg::ST_BATT +: 2] = !fl ? pcs_pkg::PCS_BATT_DEAD :
				(!sl ? pcs_pkg::PCS_BATT_WEAK : pcs_pkg::PCS_BATT_GOOD);
		v[pcs_pkg::ST_ALERT] = io & ~c[pcs_pkg::CF_RING] & (fl == pcs_pkg::ALERT_ACTIVE);
		v[pcs_pkg::ST_RING] = io & c[pcs_pkg::CF_RING] & (fl == pcs_pkg::ALERT_ACTIVE);
		v[pcs_pkg::ST_DMA] = c[pcs_pkg::CF_DMA] & (sl == pcs_pkg::DMAREQ_ACTIVE);
		v[pcs_pkg::ST_AUDIO] = io & ~c[pcs_pkg::CF_DMA] & sl;
		v[pcs_pkg::ST_IOMODE] = io;
		return v;
	endfunction

	// Comparison of a register read
	task automatic cmpWord(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Comparison of per-socket output levels
	task automatic cmpPins(input string what, input logic [1:0] exp, input logic [1:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask

	// One-cycle register write
	task automatic regWr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask

	// One-cycle register read; data taken in the cycle after the strobe
	task automatic regRd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 d = regRdData;
	endtask

	// Status register and decoded outputs against the expected slices
	task automatic checkAll(input logic [7:0] c);
		logic [7:0] e0, e1;
		e0 = expSlice(inserted[0], firstLvl[0], secondLvl[0], c[3:0]);
		e1 = expSlice(inserted[1], firstLvl[1], secondLvl[1], c[7:4]);
		regRd(pcs_pkg::REG_STATUS, rd);
		cmpWord("status", {e1, e0}, rd);
		cmpPins("present", {e1[0], e0[0]}, cardPresent);
		cmpPins("alert", {e1[3], e0[3]}, cardChangeAlert);
		cmpPins("ring", {e1[4], e0[4]}, phoneCallAlert);
		cmpPins("dma", {e1[5], e0[5]}, dmaRequest);
		cmpPins("audio", {1'b0, e1[6] ^ e0[6]}, {1'b0, mergedAudioOut});
	endtask

	// Verdict and end of run
	task automatic report_and_stop();
		if (errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Cuts a hung run short
	initial begin
		repeat (100000) @(posedge sys_clk);
		errors++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		// Reset values, width limits, read-only status and an unmapped offset
		regRd(pcs_pkg::REG_CONFIG, rd);
		cmpWord("config reset", {8'h00, pcs_pkg::CONFIG_RESET}, rd);
		regRd(pcs_pkg::REG_MASK, rd);
		cmpWord("mask reset", {8'h00, pcs_pkg::MASK_RESET}, rd);
		@(posedge sys_clk);
		#1 cmpWord("read idle", 16'h0000, regRdData);
		regWr(pcs_pkg::REG_CONFIG, 16'hffff);
		regRd(pcs_pkg::REG_CONFIG, rd);
		cmpWord("config", 16'h00ff, rd);
		regWr(pcs_pkg::REG_MASK, 16'hffff);
		regRd(pcs_pkg::REG_MASK, rd);
		cmpWord("mask", 16'h00ff, rd);
		regWr(pcs_pkg::REG_CONFIG, 16'h0000);
		regWr(pcs_pkg::REG_MASK, 16'h0000);
		regWr(4'h9, 16'hffff);
		regRd(4'h9, rd);
		cmpWord("unmapped", 16'h0000, rd);
		regWr(pcs_pkg::REG_STATUS, 16'hffff);
		regRd(pcs_pkg::REG_CONFIG, rd);
		cmpWord("config kept", 16'h0000, rd);
		regRd(pcs_pkg::REG_MASK, rd);
		cmpWord("mask kept", 16'h0000, rd);
		checkAll(8'h00);
		// Insertion passes two sync stages and the decode register
		@(posedge sys_clk);
		inserted <= 2'b01;
		repeat (2) @(posedge sys_clk);
		#1 cmpPins("present early", 2'b00, cardPresent);
		repeat (2) @(posedge sys_clk);
		#1 cmpPins("present", 2'b01, cardPresent);
		repeat (2) @(posedge sys_clk);
		#1 cmpPins("irq masked", 2'b00, {1'b0, irq});
		regRd(pcs_pkg::REG_EVENT, rd);
		cmpWord("event", 16'h0001, rd);
		regWr(pcs_pkg::REG_MASK, 16'h0001);
		#1 cmpPins("irq raised", 2'b01, {1'b0, irq});
		regWr(pcs_pkg::REG_EVENT, 16'h0001);
		#1 cmpPins("irq cleared", 2'b00, {1'b0, irq});
		regWr(pcs_pkg::REG_MASK, 16'h0000);
		// Corner table of modes and pin levels, then random ones
		for (int i = 0; i < 40; i++) begin
			if (i < 16) begin
				cfg = cfgTab[i / 4];
				f = {i[0], i[1]};
				s = 2'(i);
			end else begin
				cfg = 8'($random(seed)) & 8'h77;
				f = 2'($random(seed));
				s = 2'($random(seed));
			end
			regWr(pcs_pkg::REG_CONFIG, {8'h00, cfg});
			@(posedge sys_clk);
			inserted <= 2'b11;
			firstLvl <= f;
			secondLvl <= s;
			repeat (5) @(posedge sys_clk);
			checkAll(cfg);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
